// *** rtl/rftc_pkg.sv ***
// Operation
// - Password-enabled: compare 32 bits to stored password
// - Password mismatch: no write, regular read after
// - Wake-on-request: modulation held off until wake-up or a completed password write
// - Woken tag stays active until mismatch or reset
// - Password mode gates programming and direct access
// - Valid write: delay, then 5.6 ms programming
// - After programming, block-read the written block
// - Write errors flagged, regular read from block 1
// - Only the documented command lengths are accepted, except test opcode 01 (any length)
// - Locked block: skip programming, block-read it
// - Received lock bit written with the data
// - Erase, verify zero, program, verify ones
// - Failed verification silences modulation until command
// - Extended mode needs key 6 or 9 plus bit
// - Key 6 rejects test access, key 9 allows
// - Extended bit period is field clock over 2n+2
// - One-time-lock bit write-protects every block
// - One-time-lock with key 6 freezes configuration
// - Gap intervals decode bits; over 64 ends write
// - Opcode 00 triggers a full power-on reset
package rftc_pkg;

    // ==========
    // Timing
    localparam int unsigned CLK_PERIOD_NS  = 5;
    localparam int unsigned PROG_TIME_NS   = 5_600_000;
    localparam int unsigned PROG_CYCLES    = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned PROG_DELAY_CYC = 16;

    // ==========
    // Gap interval windows, in field clocks (nominal 24 and 54)
    localparam logic [6:0] D0_MIN     = 7'h10;
    localparam logic [6:0] D0_MAX     = 7'h1f;
    localparam logic [6:0] D1_MIN     = 7'h30;
    localparam logic [6:0] D1_MAX     = 7'h3f;
    localparam logic [6:0] GAP_TIMEOUT = 7'h40;

    // ==========
    // Command lengths in bits
    localparam logic [6:0] LEN_OPCODE    = 7'h02;
    localparam logic [6:0] LEN_DA_PLAIN  = 7'h06;
    localparam logic [6:0] LEN_WAKE      = 7'h22;
    localparam logic [6:0] LEN_STD_WRITE = 7'h26;
    localparam logic [6:0] LEN_DA_PWD    = 7'h26;
    localparam logic [6:0] LEN_PWD_WRITE = 7'h46;
    localparam int unsigned SHIFT_W      = 70;

    // ==========
    // Opcodes
    localparam logic [1:0] OP_RESET = 2'h0;
    localparam logic [1:0] OP_TEST  = 2'h1;

    // ==========
    // Configuration block fields (field bit k sits at index 32-k)
    localparam int unsigned CFG_KEY_HI  = 31;
    localparam int unsigned CFG_KEY_LO  = 28;
    localparam int unsigned CFG_RATE_HI = 22;
    localparam int unsigned CFG_RATE_LO = 17;
    localparam int unsigned CFG_XMODE   = 16;
    localparam int unsigned CFG_AOR     = 9;
    localparam int unsigned CFG_OTP     = 8;
    localparam int unsigned CFG_MAXB_HI = 7;
    localparam int unsigned CFG_MAXB_LO = 5;
    localparam int unsigned CFG_PWD     = 4;
    localparam logic [3:0]  KEY_NO_TEST = 4'h6;
    localparam logic [3:0]  KEY_TEST    = 4'h9;
    localparam logic [2:0]  FIRST_BLOCK = 3'h1;

    // ==========
    // Types
    typedef enum logic [1:0] {
        MODE_SILENT  = 2'b00,
        MODE_REGULAR = 2'b01,
        MODE_BLOCK   = 2'b10
    } rftc_mode_t;

    typedef enum logic [1:0] {
        EOP_ERASE      = 2'b00,
        EOP_ERASE_VFY  = 2'b01,
        EOP_PROGRAM    = 2'b10,
        EOP_PROG_VFY   = 2'b11
    } rftc_eop_t;

    typedef struct packed {
        rftc_eop_t   op;
        logic        page;
        logic [2:0]  blk;
        logic        lock;
        logic [31:0] data;
    } rftc_eep_cmd_t;

endpackage

// *** rtl/rftc_buf2.sv ***
`timescale 1ns/1ps
module rftc_buf2 #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    // ==========
    // Head plus skid entry; ready depends only on the skid flop
    logic         head_v_q;
    logic         skid_v_q;
    logic [W-1:0] head_q;
    logic [W-1:0] skid_q;
    wire          push = in_valid_i & ~skid_v_q;
    wire          pop  = head_v_q & out_ready_i;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            head_v_q <= 1'b0;
            skid_v_q <= 1'b0;
            head_q   <= '0;
            skid_q   <= '0;
        end
        else
        begin
            if (pop || !head_v_q)
            begin
                head_v_q <= skid_v_q | push;
                head_q   <= skid_v_q ? skid_q : in_data_i;
                skid_v_q <= 1'b0;
            end
            else if (push)
            begin
                skid_v_q <= 1'b1;
                skid_q   <= in_data_i;
            end
        end
    end

    assign in_ready_o  = ~skid_v_q;
    assign out_valid_o = head_v_q;
    assign out_data_o  = head_q;
endmodule

// *** rtl/rftc_ctrl.sv ***
`timescale 1ns/1ps
module rftc_ctrl #(
    parameter int unsigned PROG_CYCLES = rftc_pkg::PROG_CYCLES,
    parameter int unsigned DELAY_CYC   = rftc_pkg::PROG_DELAY_CYC
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_b_i,
    input  wire logic                   fc_tick_i,
    input  wire logic                   gap_i,
    input  wire logic                   cfg_valid_i,
    input  wire logic [31:0]            mode_config_block_i,
    input  wire logic [31:0]            password_block_i,
    input  wire logic [7:0]             lock_bits_i,
    output rftc_pkg::rftc_eep_cmd_t     eep_cmd_o,
    output logic                        eep_valid_o,
    input  wire logic                   eep_ready_i,
    input  wire logic                   eep_ack_i,
    input  wire logic                   eep_ok_i,
    output rftc_pkg::rftc_mode_t        mode_o,
    output logic                        mod_en_o,
    output logic [2:0]                  read_blk_o,
    output logic                        page_o,
    output logic                        write_err_o,
    output logic                        por_req_o,
    output logic                        test_req_o,
    output logic                        xmode_o,
    output logic [7:0]                  rate_div_o
);
    // ==========
    // Reset release
    logic rst_s1_q;
    logic rst_s2_q;
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire rst_b = rst_s2_q;

    // ==========
    // Configuration decode
    wire [3:0] key_w       = mode_config_block_i[rftc_pkg::CFG_KEY_HI:rftc_pkg::CFG_KEY_LO];
    wire [5:0] rate_n_w    = mode_config_block_i[rftc_pkg::CFG_RATE_HI:rftc_pkg::CFG_RATE_LO];
    wire       password_enable        = mode_config_block_i[rftc_pkg::CFG_PWD];
    wire       wake_on_request_enable = mode_config_block_i[rftc_pkg::CFG_AOR] & password_enable;
    wire       otp_w       = mode_config_block_i[rftc_pkg::CFG_OTP];
    wire       key_ok_w    = (key_w == rftc_pkg::KEY_NO_TEST) || (key_w == rftc_pkg::KEY_TEST);
    wire       xmode_w     = key_ok_w & mode_config_block_i[rftc_pkg::CFG_XMODE];
    wire       test_ok_w   = (key_w != rftc_pkg::KEY_NO_TEST);
    // Zero tells the fixed-rate generator to use the legacy table
    wire [7:0] rate_div_w  = xmode_w ? ({1'b0, rate_n_w, 1'b0} + 8'h02) : 8'h00;

    // ==========
    // State
    typedef enum logic [2:0] {
        S_IDLE     = 3'b000,
        S_RX       = 3'b001,
        S_DELAY    = 3'b010,
        S_ERASE    = 3'b011,
        S_ERASE_V  = 3'b100,
        S_PROG     = 3'b101,
        S_PROG_V   = 3'b110,
        S_SETTLE   = 3'b111
    } rftc_state_t;

    rftc_state_t                      st_q, st_d;
    rftc_pkg::rftc_mode_t             mode_q, mode_d;
    logic [2:0]                       blk_q, blk_d;
    logic                             page_q, page_d;
    logic                             awake_q, awake_d;
    logic                             boot_q, boot_d;
    logic [6:0]                       fc_q, fc_d;
    logic [6:0]                       cnt_q, cnt_d;
    logic [rftc_pkg::SHIFT_W-1:0]     sh_q, sh_d;
    logic [1:0]                       op_q, op_d;
    logic                             bad_q, bad_d;
    logic                             mism_q, mism_d;
    logic                             issued_q, issued_d;
    logic [31:0]                      tmr_q, tmr_d;
    logic [31:0]                      wdata_q, wdata_d;
    logic                             wlock_q, wlock_d;
    logic                             err_q, err_d;
    logic                             por_q, por_d;
    logic                             test_q, test_d;
    logic                             mod_en_q;
    logic                             xmode_q;
    logic [7:0]                       rate_q;

    // ==========
    // Gap interval classification
    wire       is0_w   = (fc_q >= rftc_pkg::D0_MIN) && (fc_q <= rftc_pkg::D0_MAX);
    wire       is1_w   = (fc_q >= rftc_pkg::D1_MIN) && (fc_q <= rftc_pkg::D1_MAX);
    wire       tout_w  = (fc_q > rftc_pkg::GAP_TIMEOUT);
    wire [4:0] pidx_w  = 5'(7'h21 - cnt_q);
    wire       in_pwd_w = password_enable && (cnt_q >= 7'h02) && (cnt_q <= 7'h21);
    wire       pbit_w  = password_block_i[pidx_w];
    wire [2:0] addr_w  = sh_q[2:0];
    wire       zero_ok_w = ~sh_q[3];
    wire       locked_w  = lock_bits_i[addr_w] | otp_w;
    wire       step_v_w  = (st_q == S_ERASE_V) || (st_q == S_PROG_V);
    wire       buf_ready;

    rftc_pkg::rftc_eep_cmd_t cmd_w;
    assign cmd_w.op   = (st_q == S_ERASE)   ? rftc_pkg::EOP_ERASE :
                        (st_q == S_ERASE_V) ? rftc_pkg::EOP_ERASE_VFY :
                        (st_q == S_PROG)    ? rftc_pkg::EOP_PROGRAM : rftc_pkg::EOP_PROG_VFY;
    assign cmd_w.page = page_q;
    assign cmd_w.blk  = blk_q;
    assign cmd_w.lock = wlock_q;
    assign cmd_w.data = wdata_q;
    wire   step_w     = (st_q >= S_ERASE) && (st_q <= S_PROG_V);
    wire   push_w     = step_w & ~issued_q;

    // ==========
    // Next state
    always_comb
    begin
        st_d     = st_q;
        mode_d   = mode_q;
        blk_d    = blk_q;
        page_d   = page_q;
        awake_d  = awake_q;
        boot_d   = boot_q;
        fc_d     = (fc_tick_i && fc_q != 7'h7f) ? fc_q + 7'h01 : fc_q;
        cnt_d    = cnt_q;
        sh_d     = sh_q;
        op_d     = op_q;
        bad_d    = bad_q;
        mism_d   = mism_q;
        issued_d = issued_q;
        tmr_d    = tmr_q;
        wdata_d  = wdata_q;
        wlock_d  = wlock_q;
        err_d    = 1'b0;
        por_d    = 1'b0;
        test_d   = 1'b0;
        if (gap_i)
            fc_d = 7'h00;
        case (st_q)
            S_IDLE:
            begin
                if (cfg_valid_i && !boot_q)
                begin
                    boot_d = 1'b1;
                    mode_d = wake_on_request_enable ? rftc_pkg::MODE_SILENT : rftc_pkg::MODE_REGULAR;
                    blk_d  = rftc_pkg::FIRST_BLOCK;
                end
                if (gap_i && boot_q)
                begin
                    st_d   = S_RX;
                    cnt_d  = 7'h00;
                    bad_d  = 1'b0;
                    mism_d = 1'b0;
                end
            end
            S_RX:
            begin
                if (gap_i)
                begin
                    sh_d  = {sh_q[rftc_pkg::SHIFT_W-2:0], is1_w};
                    cnt_d = (cnt_q == 7'h7f) ? cnt_q : cnt_q + 7'h01;
                    if (!is0_w && !is1_w)
                        bad_d = 1'b1;
                    if (cnt_q == 7'h00)
                        op_d[1] = is1_w;
                    if (cnt_q == 7'h01)
                        op_d[0] = is1_w;
                    if (in_pwd_w && (is1_w != pbit_w))
                        mism_d = 1'b1;
                end
                else if (tout_w)
                begin
                    st_d = S_IDLE;
                    if (op_q == rftc_pkg::OP_RESET && cnt_q == rftc_pkg::LEN_OPCODE && !bad_q)
                    begin
                        por_d   = 1'b1;
                        boot_d  = 1'b0;
                        awake_d = 1'b0;
                        mode_d  = rftc_pkg::MODE_SILENT;
                    end
                    else if (!bad_q && op_q == rftc_pkg::OP_TEST)
                    begin
                        // Test access handled outside; denied silently
                        test_d = test_ok_w;
                    end
                    else if (!bad_q && op_q[1])
                    begin
                        page_d = op_q[0];
                        // Default outcome is an error; overridden below
                        err_d  = 1'b1;
                        mode_d = rftc_pkg::MODE_REGULAR;
                        blk_d  = rftc_pkg::FIRST_BLOCK;
                        if (cnt_q == rftc_pkg::LEN_OPCODE)
                            err_d = 1'b0;
                        else if (password_enable && mism_q &&
                                 (cnt_q == rftc_pkg::LEN_WAKE || cnt_q == rftc_pkg::LEN_DA_PWD ||
                                  cnt_q == rftc_pkg::LEN_PWD_WRITE))
                        begin
                            awake_d = 1'b0;
                            if (wake_on_request_enable)
                                mode_d = rftc_pkg::MODE_SILENT;
                        end
                        else if (password_enable && cnt_q == rftc_pkg::LEN_WAKE)
                        begin
                            err_d   = 1'b0;
                            awake_d = 1'b1;
                        end
                        else if ((password_enable && cnt_q == rftc_pkg::LEN_DA_PWD) ||
                                 (!password_enable && cnt_q == rftc_pkg::LEN_DA_PLAIN))
                        begin
                            if (zero_ok_w)
                            begin
                                err_d  = 1'b0;
                                mode_d = rftc_pkg::MODE_BLOCK;
                                blk_d  = addr_w;
                            end
                        end
                        else if ((password_enable && cnt_q == rftc_pkg::LEN_PWD_WRITE) ||
                                 (!password_enable && cnt_q == rftc_pkg::LEN_STD_WRITE))
                        begin
                            err_d  = 1'b0;
                            blk_d  = addr_w;
                            mode_d = rftc_pkg::MODE_BLOCK;
                            if (!locked_w)
                            begin
                                st_d    = S_DELAY;
                                tmr_d   = 32'h0000_0000;
                                wdata_d = sh_q[34:3];
                                wlock_d = sh_q[35];
                                mode_d  = mode_q;
                            end
                        end
                        if (wake_on_request_enable && !awake_d)
                            mode_d = rftc_pkg::MODE_SILENT;
                    end
                    else
                    begin
                        err_d  = 1'b1;
                        mode_d = (wake_on_request_enable && !awake_q) ? rftc_pkg::MODE_SILENT
                                                                      : rftc_pkg::MODE_REGULAR;
                        blk_d  = rftc_pkg::FIRST_BLOCK;
                    end
                end
            end
            S_DELAY:
            begin
                tmr_d = tmr_q + 32'h0000_0001;
                if (tmr_q >= 32'(DELAY_CYC))
                    st_d = S_ERASE;
            end
            S_ERASE, S_ERASE_V, S_PROG, S_PROG_V:
            begin
                tmr_d = tmr_q + 32'h0000_0001;
                if (push_w && buf_ready)
                    issued_d = 1'b1;
                if (issued_q && eep_ack_i)
                begin
                    issued_d = 1'b0;
                    st_d     = rftc_state_t'(3'(st_q + 3'b001));
                    if (step_v_w && !eep_ok_i)
                    begin
                        st_d   = S_IDLE;
                        mode_d = rftc_pkg::MODE_SILENT;
                    end
                end
            end
            S_SETTLE:
            begin
                tmr_d = tmr_q + 32'h0000_0001;
                if (tmr_q >= 32'(PROG_CYCLES))
                begin
                    st_d   = S_IDLE;
                    mode_d = rftc_pkg::MODE_BLOCK;
                end
            end
            default:
                st_d = S_IDLE;
        endcase
    end

    // ==========
    // Registers
    always_ff @(posedge clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q     <= S_IDLE;
            mode_q   <= rftc_pkg::MODE_SILENT;
            blk_q    <= rftc_pkg::FIRST_BLOCK;
            page_q   <= 1'b0;
            awake_q  <= 1'b0;
            boot_q   <= 1'b0;
            fc_q     <= 7'h00;
            cnt_q    <= 7'h00;
            sh_q     <= '0;
            op_q     <= 2'h0;
            bad_q    <= 1'b0;
            mism_q   <= 1'b0;
            issued_q <= 1'b0;
            tmr_q    <= 32'h0000_0000;
            wdata_q  <= 32'h0000_0000;
            wlock_q  <= 1'b0;
            err_q    <= 1'b0;
            por_q    <= 1'b0;
            test_q   <= 1'b0;
        end
        else
        begin
            st_q     <= st_d;
            mode_q   <= mode_d;
            blk_q    <= blk_d;
            page_q   <= page_d;
            awake_q  <= awake_d;
            boot_q   <= boot_d;
            fc_q     <= fc_d;
            cnt_q    <= cnt_d;
            sh_q     <= sh_d;
            op_q     <= op_d;
            bad_q    <= bad_d;
            mism_q   <= mism_d;
            issued_q <= issued_d;
            tmr_q    <= tmr_d;
            wdata_q  <= wdata_d;
            wlock_q  <= wlock_d;
            err_q    <= err_d;
            por_q    <= por_d;
            test_q   <= test_d;
        end
    end

    // Output flops kept apart so the decode stays combinational
    always_ff @(posedge clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mod_en_q <= 1'b0;
            xmode_q  <= 1'b0;
            rate_q   <= 8'h00;
        end
        else
        begin
            mod_en_q <= (mode_d != rftc_pkg::MODE_SILENT);
            xmode_q  <= xmode_w;
            rate_q   <= rate_div_w;
        end
    end

    // ==========
    // Command buffer towards the memory; a stall holds the step
    rftc_buf2 #(
        .W ($bits(rftc_pkg::rftc_eep_cmd_t))
    ) u_buf (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b),
        .in_valid_i  (push_w),
        .in_ready_o  (buf_ready),
        .in_data_i   (cmd_w),
        .out_valid_o (eep_valid_o),
        .out_ready_i (eep_ready_i),
        .out_data_o  (eep_cmd_o)
    );

    assign mode_o      = mode_q;
    assign mod_en_o    = mod_en_q;
    assign read_blk_o  = blk_q;
    assign page_o      = page_q;
    assign write_err_o = err_q;
    assign por_req_o   = por_q;
    assign test_req_o  = test_q;
    assign xmode_o     = xmode_q;
    assign rate_div_o  = rate_q;
endmodule

// *** tb/rftc_ctrl_chk.sv ***
`timescale 1ns/1ps
module rftc_ctrl_chk (
    input wire logic                    clk_i,
    input wire logic                    rst_b_i,
    input wire logic [31:0]             mode_config_block_i,
    input rftc_pkg::rftc_eep_cmd_t      eep_cmd_o,
    input wire logic                    eep_valid_o,
    input wire logic                    eep_ready_i,
    input rftc_pkg::rftc_mode_t         mode_o,
    input wire logic                    mod_en_o,
    input wire logic [2:0]              read_blk_o,
    input wire logic                    write_err_o,
    input wire logic                    por_req_o,
    input wire logic                    test_req_o,
    input wire logic                    xmode_o,
    input wire logic [7:0]              rate_div_o
);
    // ==========
    // Helpers
    wire [3:0] key = mode_config_block_i[31:28];
    wire [7:0] rate = {1'b0, mode_config_block_i[22:17], 1'b0} + 8'h02;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_wait;
        eep_valid_o && !eep_ready_i;
    endsequence
    // ==========
    // Properties
    property p_mod; mod_en_o == (mode_o != rftc_pkg::MODE_SILENT); endproperty
    property p_err; write_err_o |=> !write_err_o; endproperty
    property p_eblk; write_err_o |-> ##[0:1] (read_blk_o == 3'h1 && mode_o != rftc_pkg::MODE_BLOCK); endproperty
    property p_por; por_req_o |=> !por_req_o; endproperty
    property p_hold; s_wait |=> eep_valid_o && $stable(eep_cmd_o); endproperty
    property p_xm; xmode_o && $stable(mode_config_block_i) |-> (key == 4'h6 || key == 4'h9) && mode_config_block_i[16]; endproperty
    property p_rate; xmode_o && $stable(mode_config_block_i) |-> rate_div_o == rate; endproperty
    property p_test; test_req_o && $stable(mode_config_block_i) |-> key != rftc_pkg::KEY_NO_TEST; endproperty
    a_mod: assert property (p_mod) else $error("mod enable mismatch");
    a_err: assert property (p_err) else $error("error pulse too long");
    a_eblk: assert property (p_eblk) else $error("error did not restart block one");
    a_por: assert property (p_por) else $error("reset pulse too long");
    a_hold: assert property (p_hold) else $error("memory step dropped");
    a_xm: assert property (p_xm) else $error("extended mode wrongly on");
    a_rate: assert property (p_rate) else $error("rate divider wrong");
    a_test: assert property (p_test) else $error("test access with wrong key");
endmodule
bind rftc_ctrl rftc_ctrl_chk chk_u (.clk_i, .rst_b_i, .mode_config_block_i, .eep_cmd_o, .eep_valid_o,
    .eep_ready_i, .mode_o, .mod_en_o, .read_blk_o, .write_err_o, .por_req_o, .test_req_o, .xmode_o, .rate_div_o);

// *** tb/rftc_eep_model.sv ***
`timescale 1ns/1ps
module rftc_eep_model (
    input wire logic                clk_i,
    input wire logic                valid_i,
    input wire logic                bad_i,
    input rftc_pkg::rftc_eep_cmd_t  cmd_i,
    output logic                    ready_o = 1'b0,
    output logic                    ack_o = 1'b0,
    output logic                    ok_o = 1'b0
);
    int steps = 0;
    int bad_order = 0;
    int wait_q = 0;
    rftc_pkg::rftc_eep_cmd_t last;
    // Slow memory: one cycle to accept, three to finish a step
    always @(posedge clk_i)
    begin
        ack_o <= 1'b0;
        ready_o <= valid_i && !ready_o && wait_q == 0;
        if (valid_i && ready_o)
        begin
            if (cmd_i.op !== steps[1:0]) bad_order++;
            last <= cmd_i;
            steps++;
            wait_q <= 3;
        end
        else if (wait_q > 0) wait_q <= wait_q - 1;
        if (wait_q == 1)
        begin
            ack_o <= 1'b1;
            ok_o <= !(bad_i && last.op == rftc_pkg::EOP_PROG_VFY);
        end
    end
endmodule

// *** tb/rftc_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module rftc_ctrl_tb_top;
    logic clk_i = 0, rst_b_i = 0, fc_tick_i = 0, gap_i = 0, cfg_valid_i = 0, bad = 0;
    logic [31:0] mode_config_block_i = 0, password_block_i = 0;
    logic [7:0]  lock_bits_i = 0, rate_div_o;
    rftc_pkg::rftc_eep_cmd_t eep_cmd_o;
    rftc_pkg::rftc_mode_t    mode_o;
    logic eep_valid_o, eep_ready_i, eep_ack_i, eep_ok_i, mod_en_o, page_o;
    logic write_err_o, por_req_o, test_req_o, xmode_o;
    logic [2:0]  read_blk_o;
    int fail_count = 0, check_count = 0, seed = 98, errs = 0, pors = 0, tests = 0;
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        errs += int'(write_err_o === 1'b1);
        pors += int'(por_req_o === 1'b1);
        tests += int'(test_req_o === 1'b1);
    end
    rftc_ctrl #(.PROG_CYCLES(200), .DELAY_CYC(2)) dut_u (.clk_i, .rst_b_i, .fc_tick_i, .gap_i, .cfg_valid_i,
        .mode_config_block_i, .password_block_i, .lock_bits_i, .eep_cmd_o, .eep_valid_o, .eep_ready_i,
        .eep_ack_i, .eep_ok_i, .mode_o, .mod_en_o, .read_blk_o, .page_o, .write_err_o, .por_req_o,
        .test_req_o, .xmode_o, .rate_div_o);
    rftc_eep_model p_u (.clk_i, .valid_i(eep_valid_o), .bad_i(bad), .cmd_i(eep_cmd_o),
        .ready_o(eep_ready_i), .ack_o(eep_ack_i), .ok_o(eep_ok_i));
    // ==========
    // Tasks
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        check_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [8:0] exp_x(input logic [3:0] k, input logic x, input logic [5:0] n);
        logic xm;
        xm = (k == 4'h6 || k == 4'h9) && x;
        return {xm, xm ? {1'b0, n, 1'b0} + 8'h02 : 8'h00};
    endfunction
    task automatic fc(input int n);
        repeat (n)
        begin
            @(posedge clk_i) fc_tick_i <= 1'b1;
            @(posedge clk_i) fc_tick_i <= 1'b0;
        end
    endtask
    task automatic gap;
        @(posedge clk_i) gap_i <= 1'b1;
        @(posedge clk_i) gap_i <= 1'b0;
    endtask
    // Gap spacing 24 or 54 field clocks, 70 idle ends the command
    task automatic send(input logic [69:0] b, input int n, input int w);
        gap();
        for (int i = n - 1; i >= 0; i--)
        begin
            fc(b[i] ? 54 : 24);
            gap();
        end
        fc(70);
        repeat (w) @(posedge clk_i);
    endtask
    task automatic boot(input logic [31:0] cfg);
        @(posedge clk_i) rst_b_i <= 1'b0;
        cfg_valid_i <= 1'b0;
        mode_config_block_i <= cfg;
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        cfg_valid_i <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #450000;
        fail_count++;
        wrap_up();
    end
    // ==========
    // Scenarios
    initial
    begin
        logic [2:0] a;
        logic [31:0] d, pw;
        logic [3:0] k;
        logic [5:0] n;
        logic x;
        a = $random(seed);
        a[0] = 1'b1;
        d = $random(seed);
        pw = $random(seed);
        password_block_i <= pw;
        boot(32'h0);
        chk("mod_en", 1, mod_en_o);
        send(2'b11, 2, 4);
        chk("page", 1, page_o);
        send({2'b10, 1'b0, a}, 6, 4);
        chk("da", {rftc_pkg::MODE_BLOCK, a}, {mode_o, read_blk_o});
        send({2'b10, 1'b1, d, a}, 38, 300);
        chk("wr", {rftc_pkg::MODE_BLOCK, a}, {mode_o, read_blk_o});
        chk("data", {1'b1, d}, {p_u.last.lock, p_u.last.data});
        chk("steps", 4, p_u.steps + p_u.bad_order);
        lock_bits_i <= 8'h01 << (a ^ 3'h2);
        send({2'b10, 1'b0, d, a ^ 3'h2}, 38, 30);
        chk("lk", {rftc_pkg::MODE_BLOCK, a ^ 3'h2, 32'd4}, {mode_o, read_blk_o, p_u.steps});
        mode_config_block_i <= 32'h0000_0100;
        send({2'b10, 1'b0, d, a}, 38, 30);
        chk("otp", 4, p_u.steps);
        mode_config_block_i <= 32'h0;
        send(5'b10000, 5, 4);
        chk("len", {32'd1, 3'h1}, {errs, read_blk_o});
        bad <= 1'b1;
        send({2'b10, 1'b0, d, a}, 38, 300);
        chk("vfy", {rftc_pkg::MODE_SILENT, 1'b0}, {mode_o, mod_en_o});
        bad <= 1'b0;
        send(2'b11, 2, 4);
        chk("alive", 1, mod_en_o);
        send(2'b00, 2, 4);
        chk("por", 1, pors);
        boot(32'h0000_0010);
        send({2'b10, ~pw, 1'b0, d, a}, 70, 300);
        chk("pw_bad", {32'd2, 32'd8}, {errs, p_u.steps});
        send({2'b10, pw, 1'b0, d, a}, 70, 300);
        chk("pw_ok", 12, p_u.steps);
        boot(32'h0000_0210);
        chk("aor", 0, mod_en_o);
        send({2'b10, pw}, 34, 4);
        chk("wake", 1, mod_en_o);
        send({2'b10, ~pw, 1'b0, a}, 38, 4);
        chk("sleep", 0, mod_en_o);
        for (int i = 0; i < 8; i++)
        begin
            k = (i == 0) ? 4'h6 : (i == 1) ? 4'h9 : 4'($random(seed));
            x = (i < 2) | $random(seed);
            n = $random(seed);
            mode_config_block_i <= {k, 5'h0, n, x, 16'h0};
            repeat (4) @(posedge clk_i);
            chk("xmode", exp_x(k, x, n), {xmode_o, rate_div_o});
        end
        for (int i = 0; i < 2; i++)
        begin
            mode_config_block_i <= {i ? 4'h9 : 4'h6, 28'h0};
            send(2'b01, 2, 4);
            chk("test", i, tests);
        end
        wrap_up();
    end
endmodule
